//--- hw/pwm_fault_protect_action.sv
// fault protection action unit with PWM period engine and register port
module pwm_fault_protect_action
  import prot_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic [DATA_W-1:0]  wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic      [DATA_W-1:0]  rdata,
  input  wire logic [NUM_PIN-1:0] fault_trigger,
  output logic                    pwm_out0,
  output logic                    pwm_out1,
  output logic                    pwm_out2,
  output logic                    pwm_out3,
  output logic                    irq,
  output logic      [2:0]         jitter_mode,
  output logic                    jitter_tick_en
);
  // synchroniser stages for trigger pins
  logic [NUM_PIN-1:0] trig_meta, trig_sync;
  // software visible state
  logic [7:0]         ctrl;
  logic               shutdown_flag, auto_adjust_flag;
  logic [VAL_W-1:0]   period_value, duty_value, period_decrement, period_floor;
  logic [7:0]         act_reg [3];
  logic [NUM_SRC-1:0] fault_trigger_enable;
  logic [2:0]         jit_sel;
  logic [2:0]         int_stat, int_mask;
  // protection engine state
  state_type          state;
  action_type         cur_code;
  logic [3:0]         trig_idx;
  logic [7:0]         eff_sel [3];
  logic [NUM_SRC-1:0] act_prev;
  logic [VAL_W-1:0]   cnt;
  // next values
  logic [7:0]         next_ctrl;
  logic               next_shutdown_flag, next_auto_adjust_flag;
  logic [VAL_W-1:0]   next_period_value, next_duty_value, next_period_decrement, next_period_floor;
  logic [7:0]         next_act_reg [3];
  logic [NUM_SRC-1:0] next_fault_trigger_enable;
  logic [2:0]         next_jit_sel;
  logic [2:0]         next_int_stat, next_int_mask;
  state_type          next_state;
  action_type         next_cur_code;
  logic [3:0]         next_trig_idx;
  logic [7:0]         next_eff_sel [3];
  logic [VAL_W-1:0]   next_cnt;
  logic [DATA_W-1:0]  next_rdata;
  logic [2:0]         next_jitter_mode;
  logic               next_pwm_raw;
  // decode helpers
  logic [NUM_SRC-1:0] act;
  logic               best_valid, step_ok, pwm_wrap, boundary, rel_hit;
  action_type         best_code;
  logic [3:0]         best_idx;
  logic [1:0]         fld;
  logic [VAL_W:0]     diff;
  logic               shut_now, start_adj, adj_end, pwm_run, busy;

  // two-stage synchroniser on trigger pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trig_meta <= '0;
      trig_sync <= '0;
    end else begin
      trig_meta <= fault_trigger;
      trig_sync <= trig_meta;
    end
  end

  assign pwm_run = ctrl[CB_RUN];
  assign busy    = (state != ST_IDLE);

  // period counter, boundary on last count of a period
  always_comb begin
    pwm_wrap = pwm_run && ({1'b0, cnt} + 11'h001 >= {1'b0, period_value});
    boundary = pwm_wrap || !pwm_run;
    if (!pwm_run || pwm_wrap) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 10'h001;
    end
    next_pwm_raw = pwm_run && (cnt < duty_value);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_comb begin
    act = {ctrl[CB_SWTRIG], trig_sync} & fault_trigger_enable;
  end

  // pick highest priority code among live triggers
  always_comb begin
    best_valid = 1'b0;
    best_code  = CODE_REDUCE;
    best_idx   = '0;
    fld        = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // fields at 2-bit steps, held while busy
      fld = busy ? eff_sel[i / 4][(i % 4) * 2 +: 2] : act_reg[i / 4][(i % 4) * 2 +: 2];
      if (act[i] && (!best_valid || fld < best_code)) begin
        best_valid = 1'b1;
        best_code  = action_type'(fld);
        best_idx   = 4'(i);
      end
    end
  end

  // step arithmetic and release detection
  always_comb begin
    diff    = {1'b0, period_value} - {1'b0, period_decrement};
    // floor test, also refuses an underflowing difference
    step_ok = !diff[VAL_W] && (diff[VAL_W-1:0] >= period_floor);
    rel_hit = ctrl[CB_TRACK] && (cur_code == CODE_REDUCE) && TRACK_OK[trig_idx] && !act[trig_idx];
  end

  // protection engine and register file
  always_comb begin
    next_ctrl                 = ctrl;
    next_shutdown_flag        = shutdown_flag;
    next_auto_adjust_flag     = auto_adjust_flag;
    next_period_value         = period_value;
    next_duty_value           = duty_value;
    next_period_decrement     = period_decrement;
    next_period_floor         = period_floor;
    next_act_reg              = act_reg;
    next_fault_trigger_enable = fault_trigger_enable;
    next_jit_sel              = jit_sel;
    next_int_stat             = int_stat;
    next_int_mask             = int_mask;
    next_state                = state;
    next_cur_code             = cur_code;
    next_trig_idx             = trig_idx;
    next_eff_sel              = eff_sel;
    next_rdata                = '0;
    shut_now                  = 1'b0;
    start_adj                 = 1'b0;
    adj_end                   = 1'b0;
    // software writes first, hardware events override below
    if (wr) begin
      case (addr)
        OFS_CTRL:   next_ctrl = wdata[7:0];
        OFS_STATUS: begin
          if (wdata[SB_SHUT]) next_shutdown_flag = 1'b0;
          if (wdata[SB_ADJ]) next_auto_adjust_flag = 1'b0;
        end
        OFS_PERIOD: if (state != ST_ADJUST) next_period_value = wdata[VAL_W-1:0];
        OFS_DUTY:   if (state != ST_ADJUST) next_duty_value = wdata[VAL_W-1:0];
        OFS_DEC:    if (state != ST_ADJUST) next_period_decrement = wdata[VAL_W-1:0];
        OFS_FLOOR:  if (state != ST_ADJUST) next_period_floor = wdata[VAL_W-1:0];
        OFS_ACT0:   next_act_reg[0] = wdata[7:0];
        OFS_ACT1:   next_act_reg[1] = wdata[7:0];
        OFS_ACT2:   next_act_reg[2] = wdata[7:0];
        OFS_TRIGEN: next_fault_trigger_enable = wdata[NUM_SRC-1:0];
        OFS_JITTER: next_jit_sel = wdata[2:0];
        OFS_INTST:  next_int_stat = int_stat & ~wdata[2:0];
        OFS_INTMSK: next_int_mask = wdata[2:0];
        default:    next_ctrl = ctrl;
      endcase
    end
    // fields follow software only while idle
    if (!busy) begin
      next_eff_sel = act_reg;
    end
    case (state)
      ST_IDLE: begin
        if (best_valid) begin
          next_cur_code = best_code;
          next_trig_idx = best_idx;
          // only codes 10 and 11 start reduction
          case (best_code)
            CODE_NOW:  shut_now = 1'b1;
            CODE_WAIT: next_state = ST_WAIT;
            default:   start_adj = 1'b1;
          endcase
        end
      end
      ST_ADJUST: begin
        if (ctrl[CB_STOP] || rel_hit) begin
          adj_end = 1'b1;
        end else if (pwm_wrap) begin
          // writes only at the period boundary
          if (step_ok) begin
            next_period_value = diff[VAL_W-1:0];
            // duty step by half the decrement, floor at zero
            next_duty_value = (duty_value > (period_decrement >> 1)) ?
                              duty_value - (period_decrement >> 1) : '0;
          end else begin
            adj_end = 1'b1;
          end
        end
        if (adj_end) begin
          // code 10 runs to the end of the period in progress then shuts, code 11 stops here
          next_state = (cur_code == CODE_SHUT) ? ST_LAST : ST_HOLD;
        end
      end
      // wait for the period in progress to end
      ST_LAST, ST_WAIT: begin
        if (boundary) shut_now = 1'b1;
      end
      ST_HOLD: begin
        if (!best_valid) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    // a stronger code takes over at once
    if (busy && best_valid && best_code < cur_code && !shut_now) begin
      next_cur_code = best_code;
      next_trig_idx = best_idx;
      case (best_code)
        CODE_NOW:  shut_now = 1'b1;
        CODE_WAIT: next_state = ST_WAIT;
        default:   if (next_state == ST_HOLD) next_state = ST_LAST; // ended reduction now shuts later
      endcase
    end
    if (start_adj) begin
      next_auto_adjust_flag = 1'b1;
      next_state            = ST_ADJUST;
    end
    if (shut_now) begin
      next_ctrl[CB_RUN]   = 1'b0;
      next_ctrl[CB_FSEL0] = 1'b1;
      next_ctrl[CB_FSEL1] = 1'b1;
      next_shutdown_flag  = 1'b1;
      next_state          = ST_HOLD;
      next_cur_code       = CODE_NOW;
    end
    // sticky interrupt events, set wins over clear
    if (|(act & ~act_prev)) next_int_stat[IB_FAULT] = 1'b1;
    if (shut_now) next_int_stat[IB_SHUT] = 1'b1;
    if (adj_end) next_int_stat[IB_ADJEND] = 1'b1;
    if (!jit_sel[JB_HW]) begin
      next_jitter_mode = jit_sel[JB_APPR] ? JM_SW_APPR : JM_SW_COUNT;
    end else if (jit_sel[JB_PART]) begin
      next_jitter_mode = JM_HW_PART;
    end else begin
      next_jitter_mode = jit_sel[JB_APPR] ? JM_HW_FULL : JM_HW_CNTAPP;
    end
    // read data for the next cycle
    if (rd) begin
      case (addr)
        OFS_CTRL:   next_rdata = {8'h00, ctrl};
        OFS_STATUS: next_rdata = {13'h0000, busy, auto_adjust_flag, shutdown_flag};
        OFS_PERIOD: next_rdata = {6'h00, period_value};
        OFS_DUTY:   next_rdata = {6'h00, duty_value};
        OFS_DEC:    next_rdata = {6'h00, period_decrement};
        OFS_FLOOR:  next_rdata = {6'h00, period_floor};
        OFS_ACT0:   next_rdata = {8'h00, act_reg[0]};
        OFS_ACT1:   next_rdata = {8'h00, act_reg[1]};
        OFS_ACT2:   next_rdata = {8'h00, act_reg[2]};
        OFS_TRIGEN: next_rdata = {7'h00, fault_trigger_enable};
        OFS_JITTER: next_rdata = {13'h0000, jit_sel};
        OFS_INTST:  next_rdata = {13'h0000, int_stat};
        OFS_INTMSK: next_rdata = {13'h0000, int_mask};
        default:    next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl                 <= '0;
      shutdown_flag        <= 1'b0;
      auto_adjust_flag     <= 1'b0;
      period_value         <= RST_PERIOD;
      duty_value           <= RST_DUTY;
      period_decrement     <= RST_DEC;
      period_floor         <= RST_FLOOR;
      act_reg              <= '{RST_ACT, RST_ACT, RST_ACT};
      eff_sel              <= '{RST_ACT, RST_ACT, RST_ACT};
      fault_trigger_enable <= '0;
      jit_sel              <= '0;
      int_stat             <= '0;
      int_mask             <= '0;
      state                <= ST_IDLE;
      cur_code             <= CODE_REDUCE;
      trig_idx             <= '0;
      act_prev             <= '0;
      rdata                <= '0;
      jitter_mode          <= JM_SW_COUNT;
      jitter_tick_en       <= 1'b0;
      irq                  <= 1'b0;
      pwm_out0             <= 1'b0;
      pwm_out1             <= 1'b0;
      pwm_out2             <= 1'b0;
      pwm_out3             <= 1'b0;
    end else begin
      ctrl                 <= next_ctrl;
      shutdown_flag        <= next_shutdown_flag;
      auto_adjust_flag     <= next_auto_adjust_flag;
      period_value         <= next_period_value;
      duty_value           <= next_duty_value;
      period_decrement     <= next_period_decrement;
      period_floor         <= next_period_floor;
      act_reg              <= next_act_reg;
      eff_sel              <= next_eff_sel;
      fault_trigger_enable <= next_fault_trigger_enable;
      jit_sel              <= next_jit_sel;
      int_stat             <= next_int_stat;
      int_mask             <= next_int_mask;
      state                <= next_state;
      cur_code             <= next_cur_code;
      trig_idx             <= next_trig_idx;
      act_prev             <= act;
      rdata                <= next_rdata;
      jitter_mode          <= next_jitter_mode;
      // tick timer only in hardware modes
      jitter_tick_en       <= next_jit_sel[JB_HW];
      irq                  <= |(next_int_stat & next_int_mask);
      // pairs follow the forced level when force select is set
      pwm_out0             <= next_ctrl[CB_FSEL0] ? next_ctrl[CB_FLVL0] : next_pwm_raw;
      pwm_out2             <= next_ctrl[CB_FSEL0] ? next_ctrl[CB_FLVL0] : next_pwm_raw;
      pwm_out1             <= next_ctrl[CB_FSEL1] ? next_ctrl[CB_FLVL1] : !next_pwm_raw;
      pwm_out3             <= next_ctrl[CB_FSEL1] ? next_ctrl[CB_FLVL1] : !next_pwm_raw;
    end
  end

  // checks on the protection engine
  a_immediate_stop: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_IDLE && best_valid && best_code == CODE_NOW)
    |=> (!pwm_run && ctrl[CB_FSEL0] && ctrl[CB_FSEL1] && shutdown_flag && state == ST_HOLD))
    else $error("code 00 did not shut down at once");
  a_wait_period: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_WAIT && pwm_run && !pwm_wrap && best_code != CODE_NOW && !(wr && addr == OFS_CTRL))
    |=> pwm_run)
    else $error("code 01 stopped before period end");
  a_step_write: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_ADJUST && pwm_wrap && step_ok && !ctrl[CB_STOP] && !rel_hit && !shut_now)
    |=> (period_value == $past(period_value) - $past(period_decrement)
         && (duty_value == $past(duty_value) - ($past(period_decrement) >> 1) || duty_value == '0)))
    else $error("reduction step values wrong");
  a_floor_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_ADJUST && pwm_wrap && !step_ok) |=> (period_value == $past(period_value)))
    else $error("period written below floor");
  a_stop_halt: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_ADJUST && ctrl[CB_STOP]) |=> (state != ST_ADJUST))
    else $error("stop bit did not halt reduction");
  a_release_end: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_ADJUST && rel_hit && !(best_valid && best_code < cur_code) && !(wr && addr == OFS_CTRL))
    |=> (state == ST_HOLD && pwm_run == $past(pwm_run)))
    else $error("release did not end reduction");
  a_no_adjust_start: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_IDLE && best_valid && (best_code == CODE_NOW || best_code == CODE_WAIT)) |=> (state != ST_ADJUST))
    else $error("code 00 or 01 started reduction");
  a_write_lock: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_ADJUST && wr && addr == OFS_FLOOR) |=> (period_floor == $past(period_floor)))
    else $error("floor written during reduction");
  a_trigger_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_IDLE && act == '0) |=> (state == ST_IDLE && !shutdown_flag == !$past(shutdown_flag) || $past(wr)))
    else $error("protection started without enabled trigger");
endmodule : pwm_fault_protect_action

//--- shared/prot_pkg.sv
// constants, register map and types of the fault protection action unit
package prot_pkg;
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 16;
  localparam int VAL_W   = 10;
  localparam int NUM_PIN = 8;
  localparam int NUM_SRC = 9;
  localparam int NUM_FLD = 12;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PERIOD = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_DUTY   = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_DEC    = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_FLOOR  = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_ACT0   = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_ACT1   = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_ACT2   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_TRIGEN = 4'h9;
  localparam logic [ADDR_W-1:0] OFS_JITTER = 4'hA;
  localparam logic [ADDR_W-1:0] OFS_INTST  = 4'hB;
  localparam logic [ADDR_W-1:0] OFS_INTMSK = 4'hC;
  // control register bit positions
  localparam int CB_RUN    = 0;
  localparam int CB_FSEL0  = 1;
  localparam int CB_FSEL1  = 2;
  localparam int CB_FLVL0  = 3;
  localparam int CB_FLVL1  = 4;
  localparam int CB_STOP   = 5;
  localparam int CB_TRACK  = 6;
  localparam int CB_SWTRIG = 7;
  // status bit positions
  localparam int SB_SHUT   = 0;
  localparam int SB_ADJ    = 1;
  localparam int SB_BUSY   = 2;
  // jitter select bit positions
  localparam int JB_HW     = 0;
  localparam int JB_APPR   = 1;
  localparam int JB_PART   = 2;
  // interrupt bit positions
  localparam int IB_FAULT  = 0;
  localparam int IB_SHUT   = 1;
  localparam int IB_ADJEND = 2;
  // reset values
  localparam logic [VAL_W-1:0] RST_PERIOD = 10'h1F3;
  localparam logic [VAL_W-1:0] RST_DUTY   = 10'h0F9;
  localparam logic [VAL_W-1:0] RST_DEC    = 10'h01E;
  localparam logic [VAL_W-1:0] RST_FLOOR  = 10'h190;
  localparam logic [7:0]       RST_ACT    = 8'h00;
  // release tracking only for these sources
  localparam logic [NUM_SRC-1:0] TRACK_OK = 9'h00A;
  // jitter mode codes
  localparam logic [2:0] JM_SW_COUNT  = 3'h1;
  localparam logic [2:0] JM_SW_APPR   = 3'h2;
  localparam logic [2:0] JM_HW_CNTAPP = 3'h3;
  localparam logic [2:0] JM_HW_FULL   = 3'h4;
  localparam logic [2:0] JM_HW_PART   = 3'h5;

  typedef enum logic [1:0] {
    CODE_NOW    = 2'b00,
    CODE_WAIT   = 2'b01,
    CODE_SHUT   = 2'b10,
    CODE_REDUCE = 2'b11
  } action_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADJUST = 3'b001,
    ST_LAST   = 3'b010,
    ST_WAIT   = 3'b011,
    ST_HOLD   = 3'b100
  } state_type;
endpackage : prot_pkg

//--- tb/gate_drive_model.sv
// gate drive model of the two half-bridge legs, counting shoot-through cycles
module gate_drive_model (
  input  wire logic ref_clk,
  input  wire logic hi_a,
  input  wire logic lo_a,
  input  wire logic hi_b,
  input  wire logic lo_b,
  output int        overlap
);
  timeunit 1ns;
  timeprecision 1ns;
  // both switches of one leg on together would short the supply
  initial begin
    overlap = 0;
    forever @(posedge ref_clk) begin
      if ((hi_a && lo_a) || (hi_b && lo_b)) overlap <= overlap + 1;
    end
  end
endmodule : gate_drive_model

//--- tb/pwm_fault_protect_action_tb.sv
// self-checking bench of the fault protection action unit
module pwm_fault_protect_action_tb import prot_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic               ref_clk, rst, wr, rd, irq, jitter_tick_en;
  logic               pwm_out0, pwm_out1, pwm_out2, pwm_out3;
  logic [2:0]         jitter_mode;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdata, rdata, v;
  logic [NUM_PIN-1:0] fault_trigger;
  int                 num_errors, checks_done, overlap, seed, p, d, e;
  int                 qp[$], qd[$];
  logic [ADDR_W-1:0]  ofs_tab [5] = '{OFS_PERIOD, OFS_DUTY, OFS_DEC, OFS_FLOOR, 4'hF};
  logic [DATA_W-1:0]  rst_tab [5] = '{16'(RST_PERIOD), 16'(RST_DUTY), 16'(RST_DEC), 16'(RST_FLOOR), 16'h0000};

  pwm_fault_protect_action i_pwm_fault_protect_action (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .fault_trigger, .pwm_out0, .pwm_out1, .pwm_out2, .pwm_out3, .irq, .jitter_mode, .jitter_tick_en);
  gate_drive_model i_gate_drive_model (.ref_clk, .hi_a(pwm_out0), .lo_a(pwm_out1), .hi_b(pwm_out2),
    .lo_b(pwm_out3), .overlap);

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] dat);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dat;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data is taken in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] r);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : rd_reg

  // bounded poll until masked value matches
  task automatic poll(input logic [3:0] a, input logic [15:0] m, input logic [15:0] x, input int n);
    logic [15:0] r;
    for (int i = 0; i < n; i++) begin
      rd_reg(a, r);
      if ((r & m) === x) break;
    end
    chk(r & m, x);
  endtask : poll

  task automatic drive_trig(input logic [7:0] t);
    @(posedge ref_clk);
    fault_trigger <= t;
  endtask : drive_trig

  task automatic reset_dut;
    @(posedge ref_clk);
    rst <= 1'b1;
    fault_trigger <= '0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : reset_dut

  task automatic final_report;
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end

  initial begin
    {rst, wr, rd, addr, wdata, fault_trigger} = '0;
    rst = 1'b1;
    seed = 32'hed41;
    // expected reduction walk from reset values
    p = RST_PERIOD;
    d = RST_DUTY;
    while (p - int'(RST_DEC) >= int'(RST_FLOOR)) begin
      p -= int'(RST_DEC);
      d -= int'(RST_DEC) / 2;
      qp.push_back(p);
      qd.push_back(d);
    end
    reset_dut();
    for (int i = 0; i < 5; i++) begin
      rd_reg(ofs_tab[i], v);
      chk(v, rst_tab[i]);
    end
    $display("test reset values done");
    // immediate shutdown, disabled source, interrupt
    wr_reg(OFS_CTRL, 16'h0009);
    wr_reg(OFS_TRIGEN, 16'h0001);
    wr_reg(OFS_INTMSK, 16'h0001);
    drive_trig(8'h08);
    repeat (10) @(posedge ref_clk);
    rd_reg(OFS_CTRL, v);
    chk(v & 16'h0001, 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    drive_trig(8'h09);
    poll(OFS_CTRL, 16'h001F, 16'h000E, 8);
    rd_reg(OFS_STATUS, v);
    chk(v & 16'h0003, 16'h0001);
    repeat (2) @(posedge ref_clk);
    #1 chk({12'h0, pwm_out0, pwm_out1, pwm_out2, pwm_out3}, 16'h000A);
    chk({15'h0, irq}, 16'h0001);
    drive_trig(8'h00);
    wr_reg(OFS_INTST, 16'h0001);
    repeat (2) @(posedge ref_clk);
    #1 chk({15'h0, irq}, 16'h0000);
    $display("test immediate shutdown done");
    // code 10 full walk with blocked write and deferred field change
    reset_dut();
    wr_reg(OFS_CTRL, 16'h0001);
    wr_reg(OFS_ACT0, 16'h0020);
    wr_reg(OFS_TRIGEN, 16'h0004);
    drive_trig(8'h04);
    for (int i = 0; i < qp.size(); i++) begin
      poll(OFS_PERIOD, 16'h03FF, 16'(qp[i]), 1200);
      rd_reg(OFS_DUTY, v);
      chk(v, 16'(qd[i]));
      if (i == 0) begin
        wr_reg(OFS_PERIOD, 16'h03FF);
        wr_reg(OFS_ACT0, 16'h0030);
        rd_reg(OFS_STATUS, v);
        chk(v & 16'h0002, 16'h0002);
      end
    end
    repeat (300) @(posedge ref_clk);
    rd_reg(OFS_CTRL, v);
    chk(v & 16'h0001, 16'h0001);
    poll(OFS_CTRL, 16'h0007, 16'h0006, 600);
    rd_reg(OFS_PERIOD, v);
    chk(v, 16'(qp[qp.size()-1]));
    #1 chk({12'h0, pwm_out0, pwm_out1, pwm_out2, pwm_out3}, 16'h0000);
    $display("test reduce and shut done");
    // code 11 reduce only, then preempted by code 00
    reset_dut();
    wr_reg(OFS_CTRL, 16'h0001);
    wr_reg(OFS_ACT0, 16'h0030);
    wr_reg(OFS_TRIGEN, 16'h0005);
    drive_trig(8'h04);
    poll(OFS_PERIOD, 16'h03FF, 16'(qp[qp.size()-1]), 2000);
    repeat (1000) @(posedge ref_clk);
    rd_reg(OFS_STATUS, v);
    chk(v & 16'h0001, 16'h0000);
    rd_reg(OFS_CTRL, v);
    chk(v & 16'h0001, 16'h0001);
    drive_trig(8'h05);
    poll(OFS_CTRL, 16'h0001, 16'h0000, 8);
    $display("test reduce only done");
    // release tracking on source 1
    reset_dut();
    wr_reg(OFS_CTRL, 16'h0041);
    wr_reg(OFS_ACT0, 16'h000C);
    wr_reg(OFS_TRIGEN, 16'h0002);
    drive_trig(8'h02);
    poll(OFS_PERIOD, 16'h03FF, 16'(qp[0]), 1200);
    drive_trig(8'h00);
    repeat (1100) @(posedge ref_clk);
    rd_reg(OFS_PERIOD, v);
    chk(v, 16'(qp[0]));
    rd_reg(OFS_CTRL, v);
    chk(v & 16'h0001, 16'h0001);
    $display("test release tracking done");
    // code 01 by the software trigger waits for the period end
    reset_dut();
    wr_reg(OFS_ACT2, 16'h0001);
    wr_reg(OFS_TRIGEN, 16'h0100);
    wr_reg(OFS_CTRL, 16'h0081);
    rd_reg(OFS_STATUS, v);
    chk(v & 16'h0007, 16'h0004);
    repeat (300) @(posedge ref_clk);
    rd_reg(OFS_CTRL, v);
    chk(v & 16'h0001, 16'h0001);
    poll(OFS_CTRL, 16'h0007, 16'h0006, 400);
    rd_reg(OFS_INTST, v);
    chk(v, 16'h0003);
    $display("test wait for period end done");
    // software stop bit in mid reduction
    reset_dut();
    wr_reg(OFS_CTRL, 16'h0001);
    wr_reg(OFS_ACT0, 16'h0080);
    wr_reg(OFS_TRIGEN, 16'h0008);
    drive_trig(8'h08);
    poll(OFS_PERIOD, 16'h03FF, 16'(qp[0]), 1200);
    wr_reg(OFS_CTRL, 16'h0021);
    repeat (1100) @(posedge ref_clk);
    rd_reg(OFS_PERIOD, v);
    chk(v, 16'(qp[0]));
    rd_reg(OFS_CTRL, v);
    chk(v & 16'h0001, 16'h0000);
    $display("test stop bit done");
    // random jitter selections
    for (int i = 0; i < 12; i++) begin
      e = $random(seed) & 7;
      wr_reg(OFS_JITTER, 16'(e));
      repeat (2) @(posedge ref_clk);
      p = (e & 1) == 0 ? 1 + (e >> 1 & 1) : (e & 4) != 0 ? 5 : 3 + (e >> 1 & 1);
      #1 chk({12'h0, jitter_tick_en, jitter_mode}, 16'(p + (e & 1) * 8));
    end
    $display("test jitter modes done");
    chk(16'(overlap), 16'h0000);
    final_report();
  end
endmodule : pwm_fault_protect_action_tb
